// File: design/hcpc_top.sv
// Hardware cursor compositor: APB registers, pattern fetch, pixel merge
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// R1 - Fetch offsets 0..63, two per row
// R2 - Offsets count from pattern address register
// R3 - Pattern starts map 0; MSB is leftmost
// R4 - Packed modes: low address bits pick map
// R5 - Software loads pattern then sets address
// R6 - Upper pixel bit AND, lower bit XOR
// R7 - Color mode field selects drawing mode
// R8 - 00 zeros/secondary, 01 ones/primary, 10 transparent
// R9 - 11 inverted, special, or auxiliary color
// R10 - Special equals background XNOR auxiliary color
// R11 - Software loads aux with XNOR of colors
// R12 - Operate on palette output pixels
// R13 - 256-color: replace or invert, no protection
// R14 - Protection copies upper aux bits
// R15 - Protect two bits, four when wide
// R16 - Outside or transparent: pass background
module hcpc_top
   import hcpc_pkg::*;
#(
   parameter int FIFO_DEPTH = HCPC_FIFO_DEPTH
)
(
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Display memory read port for the pattern
   output logic mem_req,
   output logic [17:0] mem_addr,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata,
   // Frame start: reload the pattern
   input wire logic frame_start,
   // Background pixels from the palette
   input wire hcpc_pix_s pix_in,
   input wire logic pix_in_valid,
   output logic pix_in_ready,
   // Composited pixels
   output logic [7:0] pix_out,
   output logic pix_out_valid,
   input wire logic pix_out_ready
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      hcpc_fetch_e fsm; // Pattern fetch sequencer
      logic [5:0] fidx; // Offset being fetched
      logic pat_valid; // Pattern fully loaded
      logic [HCPC_PAT_WORDS-1:0][31:0] pat; // Local pattern copy
      hcpc_ctrl_s ctrl; // Cursor control
      logic [17:0] pat_base; // Pattern base address
      logic [10:0] cx; // Cursor left column
      logic [10:0] cy; // Cursor top row
      logic [7:0] prim; // Primary color
      logic [7:0] sec; // Secondary color
      logic [7:0] aux; // Auxiliary color
      logic [31:0] rdata; // APB read data
      logic err; // APB error for unmapped address
      logic req; // Memory request held until the last offset's ack
      logic [17:0] addr; // Memory address
      logic ovalid; // Output stage full
      logic [7:0] opix; // Output pixel
   } hcpc_state_s;

   hcpc_state_s s_ff; // Registered state
   hcpc_state_s nxt_s; // Next state

   hcpc_pix_s fifo_pix; // FIFO head pixel
   logic fifo_valid; // FIFO head present
   logic stage_ready; // Output stage can take a pixel

   // ------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------
   // Byte of one map from a fetched word; map n sits in bits 8n+7:8n
   function automatic logic [7:0] hcpc_map_byte(input logic [31:0] word,
                                                 input logic [1:0] map);
      hcpc_map_byte = word[{map, 3'b000} +: 8]; // R4
   endfunction

   // Two-bit cursor code for a column inside one offset word
   function automatic logic [1:0] hcpc_code(input logic [31:0] word,
                                            input logic [3:0] col);
      logic [7:0] and_b;
      logic [7:0] xor_b;
      logic [2:0] bitpos;
      // Columns 0-7 use maps 0/1, columns 8-15 maps 2/3
      and_b = hcpc_map_byte(word, {col[3], 1'b0}); // R3
      xor_b = hcpc_map_byte(word, {col[3], 1'b1}); // R3
      // Leftmost column lives in the high bit
      bitpos = 3'd7 - col[2:0]; // R3
      hcpc_code = {and_b[bitpos], xor_b[bitpos]}; // R6
   endfunction

   // Merge one cursor code with the background
   function automatic logic [7:0] hcpc_compose(input logic [1:0] code,
                                               input logic [7:0] bg,
                                               input hcpc_ctrl_s c,
                                               input logic [7:0] prim,
                                               input logic [7:0] sec,
                                               input logic [7:0] aux);
      logic [7:0] r;
      r = bg;
      unique case (code) // R7
         2'b00: r = (c.cmode == 2'd0) ? 8'h00 : sec; // R8
         2'b01: r = (c.cmode == 2'd0) ? 8'hFF : prim; // R8
         2'b10: r = bg; // R8
         2'b11:
         begin
            unique case (c.cmode) // R9
               2'd0, 2'd1: r = ~bg; // R9
               2'd2: r = ~(bg ^ aux); // R10
               2'd3: r = aux; // R9
            endcase
         end
      endcase
      // Protection only outside 256-color modes and only where drawn
      if (c.protect && !c.mode256 && code != 2'b10) // R13
      begin
         if (c.wide_prot)
         begin
            r[7:4] = aux[7:4]; // R14 R15
         end
         else
         begin
            r[7:6] = aux[7:6]; // R14 R15
         end
      end
      hcpc_compose = r;
   endfunction

   // ------------------------------------------------------------
   // Input FIFO
   // ------------------------------------------------------------
   // Palette output enters here; the merge works on it, never on
   // display memory data ahead of the palette
   hcpc_fifo #(
      .WIDTH($bits(hcpc_pix_s)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .pclk(pclk),
      .presetn(presetn),
      .in_data(pix_in), // R12
      .in_valid(pix_in_valid),
      .in_ready(pix_in_ready),
      .out_data(fifo_pix),
      .out_valid(fifo_valid),
      .out_ready(stage_ready)
   );

   // The output stage drains the FIFO only while its own slot is empty or being drained
   assign stage_ready = !s_ff.ovalid || pix_out_ready;

   // ------------------------------------------------------------
   // Port drive
   // ------------------------------------------------------------
   assign pready = 1'b1; // Zero wait states
   assign prdata = s_ff.rdata;
   assign pslverr = s_ff.err;
   assign mem_req = s_ff.req;
   assign mem_addr = s_ff.addr;
   assign pix_out = s_ff.opix;
   assign pix_out_valid = s_ff.ovalid;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      logic wr_acc; // APB write in access phase
      logic rd_setup; // APB setup phase
      logic start; // Fetch request
      logic [10:0] dx; // Column inside cursor
      logic [10:0] dy; // Row inside cursor
      logic hit; // Pixel under cursor
      logic [5:0] ofs; // Pattern offset for this pixel
      logic [1:0] code; // Cursor code for this pixel
      wr_acc = psel && penable && pwrite;
      rd_setup = psel && !penable;
      start = frame_start;
      dx = fifo_pix.x - s_ff.cx;
      dy = fifo_pix.y - s_ff.cy;
      hit = 1'b0;
      ofs = 6'h00;
      code = 2'b10;
      nxt_s = s_ff;

      // Register writes take effect at the access edge
      if (wr_acc)
      begin
         unique case (paddr)
            HCPC_OFS_CTRL: nxt_s.ctrl = pwdata[5:0]; // R7
            // A new base also moves the remaining addresses of a fetch already running; the loaded copy stays until a fetch replaces it
            HCPC_OFS_PATADDR: nxt_s.pat_base = pwdata[17:0]; // R5
            HCPC_OFS_POS:
            begin
               nxt_s.cx = pwdata[10:0];
               nxt_s.cy = pwdata[HCPC_POS_Y_LSB +: 11];
            end
            HCPC_OFS_PRIMARY: nxt_s.prim = pwdata[7:0];
            HCPC_OFS_SECONDARY: nxt_s.sec = pwdata[7:0];
            HCPC_OFS_AUX: nxt_s.aux = pwdata[7:0]; // R11
            HCPC_OFS_FETCH: start = frame_start || pwdata[0];
            default: ;
         endcase
      end

      // Read data and error are prepared in the setup cycle
      if (rd_setup)
      begin
         nxt_s.err = 1'b0;
         unique case (paddr)
            HCPC_OFS_CTRL: nxt_s.rdata = {26'h000_0000, s_ff.ctrl};
            HCPC_OFS_PATADDR: nxt_s.rdata = {14'h0000, s_ff.pat_base};
            HCPC_OFS_POS: nxt_s.rdata = {5'h00, s_ff.cy, 5'h00, s_ff.cx};
            HCPC_OFS_PRIMARY: nxt_s.rdata = {24'h00_0000, s_ff.prim};
            HCPC_OFS_SECONDARY: nxt_s.rdata = {24'h00_0000, s_ff.sec};
            HCPC_OFS_AUX: nxt_s.rdata = {24'h00_0000, s_ff.aux};
            HCPC_OFS_STATUS:
            begin
               nxt_s.rdata = 32'h0000_0000;
               nxt_s.rdata[HCPC_ST_BUSY] = (s_ff.fsm == HCPC_F_READ);
               nxt_s.rdata[HCPC_ST_VALID] = s_ff.pat_valid;
               nxt_s.rdata[HCPC_ST_OUTV] = s_ff.ovalid;
            end
            HCPC_OFS_FETCH: nxt_s.rdata = 32'h0000_0000;
            default:
            begin
               // Unmapped: zero data with an error
               nxt_s.rdata = 32'h0000_0000;
               nxt_s.err = 1'b1;
            end
         endcase
      end

      // Pattern fetch sequencer: one word of four map bytes per offset
      unique case (s_ff.fsm)
         HCPC_F_IDLE:
         begin
            if (start)
            begin
               // Pattern is unusable while being replaced
               nxt_s.pat_valid = 1'b0;
               nxt_s.fidx = 6'h00;
               nxt_s.req = 1'b1;
               nxt_s.addr = s_ff.pat_base; // R2
               nxt_s.fsm = HCPC_F_READ;
            end
         end
         HCPC_F_READ:
         begin
            if (s_ff.req && mem_ack)
            begin
               // Byte 0 of the word is map 0: the pattern's first byte
               nxt_s.pat[s_ff.fidx] = mem_rdata; // R3
               if (s_ff.fidx == HCPC_LAST_OFS) // R1
               begin
                  nxt_s.req = 1'b0;
                  nxt_s.pat_valid = 1'b1;
                  nxt_s.fsm = HCPC_F_IDLE;
               end
               else
               begin
                  nxt_s.fidx = s_ff.fidx + 6'h01; // R1
                  nxt_s.addr = s_ff.pat_base + {12'h000, s_ff.fidx} + 18'h0_0001; // R2
               end
            end
         end
      endcase

      // Cursor coverage: unsigned wrap makes left/top misses large
      hit = s_ff.ctrl.enable && s_ff.pat_valid &&
            (dx < HCPC_CUR_DIM) && (dy < HCPC_CUR_DIM);
      // Row r, column c lives at offset 2r + c/16
      ofs = {dy[4:0], dx[4]}; // R1
      code = hcpc_code(s_ff.pat[ofs], dx[3:0]);

      // Output stage: load when free or being drained
      if (stage_ready)
      begin
         nxt_s.ovalid = fifo_valid;
         if (fifo_valid)
         begin
            if (hit)
            begin
               nxt_s.opix = hcpc_compose(code, fifo_pix.bg, s_ff.ctrl,
                                         s_ff.prim, s_ff.sec, s_ff.aux); // R12
            end
            else
            begin
               nxt_s.opix = fifo_pix.bg; // R16
            end
         end
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   // Pattern copy is cleared too so reset leaves no stale cursor
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_ff <= '0;
         s_ff.fsm <= HCPC_F_IDLE;
         s_ff.ctrl <= HCPC_RST_CTRL;
         s_ff.pat_base <= HCPC_RST_PATADDR;
         s_ff.cx <= HCPC_RST_POS;
         s_ff.cy <= HCPC_RST_POS;
         s_ff.prim <= HCPC_RST_COLOR;
         s_ff.sec <= HCPC_RST_COLOR;
         s_ff.aux <= HCPC_RST_COLOR;
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

endmodule
`default_nettype wire

// File: design/hcpc_pkg.sv
// Shared constants and types for the hardware cursor pixel compositor
package hcpc_pkg;

   // ------------
   // Register byte offsets on the APB slave
   // ------------
   localparam logic [7:0] HCPC_OFS_CTRL = 8'h00; // Cursor control
   localparam logic [7:0] HCPC_OFS_PATADDR = 8'h04; // Pattern base address
   localparam logic [7:0] HCPC_OFS_POS = 8'h08; // Cursor x and y position
   localparam logic [7:0] HCPC_OFS_PRIMARY = 8'h0C; // Primary color
   localparam logic [7:0] HCPC_OFS_SECONDARY = 8'h10; // Secondary color
   localparam logic [7:0] HCPC_OFS_AUX = 8'h14; // Auxiliary color
   localparam logic [7:0] HCPC_OFS_STATUS = 8'h18; // Read-only state
   localparam logic [7:0] HCPC_OFS_FETCH = 8'h1C; // Write 1 to reload pattern

   // ------------
   // Field positions
   // ------------
   localparam int HCPC_POS_Y_LSB = 16; // Cursor y sits in POS[26:16]
   localparam int HCPC_ST_BUSY = 0; // STATUS: pattern fetch running
   localparam int HCPC_ST_VALID = 1; // STATUS: pattern loaded
   localparam int HCPC_ST_OUTV = 2; // STATUS: output stage holds a pixel

   // ------------
   // Reset values
   // ------------
   localparam logic [5:0] HCPC_RST_CTRL = 6'h00;
   localparam logic [17:0] HCPC_RST_PATADDR = 18'h0_0000;
   localparam logic [10:0] HCPC_RST_POS = 11'h000;
   localparam logic [7:0] HCPC_RST_COLOR = 8'h00;

   // ------------
   // Pattern geometry: 32 by 32, two offsets per row
   // ------------
   localparam int HCPC_PAT_WORDS = 64; // Offsets 0 through 63
   localparam logic [5:0] HCPC_LAST_OFS = 6'h3F; // Last offset fetched
   localparam logic [10:0] HCPC_CUR_DIM = 11'h020; // Cursor edge in pixels
   localparam int HCPC_FIFO_DEPTH = 16; // Pixel FIFO depth

   // ------------
   // Types
   // ------------
   // Cursor control fields, LSB first: mode[1:0], protect, enable, 256, wide
   typedef struct packed {
      logic wide_prot; // Attribute mode bit 7 copy: protect four bits
      logic mode256; // Display runs a 256-color mode
      logic enable; // Cursor shown
      logic protect; // Plane protection on
      logic [1:0] cmode; // Cursor color mode 0 to 3
   } hcpc_ctrl_s;

   // One background pixel leaving the palette stage
   typedef struct packed {
      logic [10:0] x; // Screen column
      logic [10:0] y; // Screen row
      logic [7:0] bg; // Palette output value
   } hcpc_pix_s;

   // Pattern fetch sequencer, one-hot
   typedef enum logic [1:0] {
      HCPC_F_IDLE = 2'b01,
      HCPC_F_READ = 2'b10
   } hcpc_fetch_e;

endpackage

// File: design/hcpc_fifo.sv
// Parameterised valid/ready FIFO for the pixel path
`timescale 1ns/1ps
`default_nettype none
module hcpc_fifo
   import hcpc_pkg::*;
#(
   parameter int WIDTH = 30,
   parameter int DEPTH = 16
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);

   localparam int AW = $clog2(DEPTH);

   // Storage plus pointers carrying one extra wrap bit
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0] wp;
      logic [AW:0] rp;
   } hcpc_fifo_st_s;

   hcpc_fifo_st_s s_ff; // Registered state
   hcpc_fifo_st_s nxt_s; // Next state
   logic [AW:0] used; // Words held

   // ------------------------------------------------------------
   // Flags
   // ------------------------------------------------------------
   // Full and empty come straight from the pointer distance
   assign used = s_ff.wp - s_ff.rp;
   assign in_ready = (used != DEPTH[AW:0]);
   assign out_valid = (used != '0);
   assign out_data = s_ff.mem[s_ff.rp[AW-1:0]];

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      nxt_s = s_ff;
      // Push when not full
      if (in_valid && in_ready)
      begin
         nxt_s.mem[s_ff.wp[AW-1:0]] = in_data;
         nxt_s.wp = s_ff.wp + 1'b1;
      end
      // Pop when the drain side takes the head word
      if (out_valid && out_ready)
      begin
         nxt_s.rp = s_ff.rp + 1'b1;
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_ff <= '0;
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

endmodule
`default_nettype wire

// File: dv/hcpc_props.sv
// Port checker for the cursor compositor, bound in
`timescale 1ns/1ps
`default_nettype none
module hcpc_props
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic mem_req,
   input wire logic [17:0] mem_addr,
   input wire logic mem_ack,
   input wire logic [7:0] pix_out,
   input wire logic pix_out_valid,
   input wire logic pix_out_ready
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ------------
   // Fetched word count
   // ------------
   logic [6:0] ack_cnt_ff; // Zero outside a fetch; a cut fetch shows short
   // Count accepted words while a request stands
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ack_cnt_ff <= 7'h00;
      end
      else
      begin
         ack_cnt_ff <= mem_req ? ack_cnt_ff + {6'h00, mem_ack} : 7'h00;
      end
   end
   // ------------
   // Sequences and assertions
   // ------------
   sequence s_word;
      mem_req && mem_ack;
   endsequence
   sequence s_wait;
      mem_req && !mem_ack;
   endsequence
   a_fetch_count: assert property ($fell(mem_req) |-> ack_cnt_ff == 7'h40)
      else $error("fetch not 64 words");
   a_addr_step: assert property (s_word |=> !mem_req || mem_addr == $past(mem_addr) + 18'h0_0001)
      else $error("address not stepped by one");
   a_req_hold: assert property (s_wait |=> mem_req && $stable(mem_addr))
      else $error("request dropped or moved early");
   a_req_ends: assert property ($fell(mem_req) |-> $past(mem_ack))
      else $error("request ended unacknowledged");
   a_out_hold: assert property (pix_out_valid && !pix_out_ready |=> pix_out_valid && $stable(pix_out))
      else $error("output pixel changed while stalled");
   a_ready_high: assert property (psel && penable |-> pready)
      else $error("bus access phase without ready");
   a_bad_addr: assert property (psel && penable && paddr[7:5] != 3'h0 |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_good_addr: assert property (psel && penable && paddr[7:5] == 3'h0 && paddr[1:0] == 2'h0
      |-> !pslverr)
      else $error("mapped access refused");
   c_fetch_done: cover property ($fell(mem_req));
endmodule
bind hcpc_top hcpc_props i_hcpc_props (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
   .pix_out(pix_out), .pix_out_valid(pix_out_valid), .pix_out_ready(pix_out_ready));
`default_nettype wire

// File: dv/hcpc_mem_model.sv
// Display memory model answering the pattern fetch port
`timescale 1ns/1ps
`default_nettype none
module hcpc_mem_model
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic mem_req,
   input wire logic [17:0] mem_addr,
   output logic mem_ack,
   output logic [31:0] mem_rdata
);
   logic [31:0] mem [int]; // Sparse memory, one word of four maps per offset
   logic slow = 1'b0; // Random ack stalls when set
   logic [17:0] base = 18'h0_0000; // Pattern base
   int addr_err; // Words taken outside the pattern
   logic [31:0] last_ff; // Read data of the previous cycle
   // ------------
   // Acknowledge
   // ------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mem_ack <= 1'b0;
         last_ff <= 32'h0000_0000;
         addr_err <= 0;
      end
      else
      begin
         mem_ack <= mem_req && (!slow || $urandom_range(0, 2) == 0);
         last_ff <= mem_rdata;
         if (mem_req && mem_ack && (mem_addr - base) > 18'h0_003F)
         begin
            addr_err <= addr_err + 1;
         end
      end
   end
   // Byte n is map n; idle bus shows the previous cycle's read data inverted
   always_comb
   begin
      mem_rdata = ~last_ff;
      if (mem_ack && mem.exists(int'(mem_addr)))
      begin
         mem_rdata = mem[int'(mem_addr)];
      end
   end
endmodule
`default_nettype wire

// File: dv/hcpc_top_tb.sv
// Self-checking bench for the cursor compositor
`timescale 1ns/1ps
`default_nettype none
module hcpc_top_tb
   import hcpc_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, frame_start = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, mem_rdata;
   logic pready, pslverr, mem_req, mem_ack, pix_in_ready, pix_out_valid;
   logic [17:0] mem_addr;
   hcpc_pix_s pix_in = '0;
   logic pix_in_valid = 1'b0, pix_out_ready = 1'b0;
   logic [7:0] pix_out;
   int failures = 0;
   int cmp_count = 0;
   logic [31:0] pat [64]; // Loaded pattern
   hcpc_ctrl_s ctl;
   logic [10:0] cx, cy;
   logic [7:0] prim, sec, aux;
   logic [7:0] expq [$]; // Expected pixels
   always #20 pclk = ~pclk;
   hcpc_top #(.FIFO_DEPTH(16)) i_hcpc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_addr(mem_addr),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata), .frame_start(frame_start), .pix_in(pix_in),
      .pix_in_valid(pix_in_valid), .pix_in_ready(pix_in_ready), .pix_out(pix_out),
      .pix_out_valid(pix_out_valid), .pix_out_ready(pix_out_ready));
   hcpc_mem_model i_hcpc_mem_model (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
      .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   // ------------
   // Helpers
   // ------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         failures++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Setup, then access until pready
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] x,
      input logic xerr);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      check(nm, r, x);
      check(nm, {31'h0, e}, {31'h0, xerr});
   endtask
   // Expected output for one pixel
   function automatic logic [7:0] exp_pix(input hcpc_pix_s p);
      logic [10:0] dx, dy;
      logic [31:0] w;
      int n, b;
      logic [1:0] code;
      logic [7:0] o;
      dx = p.x - cx;
      dy = p.y - cy;
      if (!ctl.enable || dx > 11'h01F || dy > 11'h01F) return p.bg;
      w = pat[{dy[4:0], dx[4]}];
      n = 16 * int'(dx[3]);
      b = 7 - int'(dx[2:0]);
      code = {w[n + b], w[n + 8 + b]};
      case (code)
         2'h0: o = (ctl.cmode == 2'h0) ? 8'h00 : sec;
         2'h1: o = (ctl.cmode == 2'h0) ? 8'hFF : prim;
         2'h2: return p.bg;
         default: o = (ctl.cmode < 2'h2) ? ~p.bg : (ctl.cmode == 2'h2) ? ~(p.bg ^ aux) : aux;
      endcase
      if (ctl.protect && !ctl.mode256)
      begin
         o[7:6] = aux[7:6];
         if (ctl.wide_prot) o[5:4] = aux[5:4];
      end
      return o;
   endfunction
   function automatic hcpc_pix_s rnd_pix();
      hcpc_pix_s p;
      p.x = cx + 11'($urandom_range(0, 40)) - 11'h004;
      p.y = cy + 11'($urandom_range(0, 40)) - 11'h004;
      p.bg = 8'($urandom);
      return p;
   endfunction
   task automatic load(input logic by_frame, input logic slw);
      logic [17:0] base;
      base = 18'($urandom_range(0, 32'h0003_FF00));
      i_hcpc_mem_model.slow = slw;
      i_hcpc_mem_model.base = base;
      for (int i = 0; i < 64; i++)
      begin
         pat[i] = $urandom;
         i_hcpc_mem_model.mem[int'(base) + i] = pat[i];
      end
      wr(HCPC_OFS_PATADDR, {14'h0000, base});
      if (by_frame)
      begin
         @(posedge pclk);
         frame_start <= 1'b1;
         @(posedge pclk);
         frame_start <= 1'b0;
      end
      else wr(HCPC_OFS_FETCH, 32'h0000_0001);
      repeat (400) @(posedge pclk);
      rdchk("status", HCPC_OFS_STATUS, 32'h0000_0002, 1'b0);
      check("fetch range", i_hcpc_mem_model.addr_err, 0);
   endtask
   task automatic cfg(input logic [1:0] m, input logic prot, input logic wid, input logic en);
      ctl = '{wid, 1'($urandom), en, prot, m};
      cx = 11'($urandom);
      cy = 11'($urandom);
      prim = 8'($urandom);
      sec = 8'($urandom);
      aux = 8'($urandom);
      wr(HCPC_OFS_CTRL, {26'h0, ctl});
      wr(HCPC_OFS_POS, {5'h00, cy, 5'h00, cx});
      wr(HCPC_OFS_PRIMARY, {24'h0, prim});
      wr(HCPC_OFS_SECONDARY, {24'h0, sec});
      wr(HCPC_OFS_AUX, {24'h0, aux});
   endtask
   // Pixels in; outputs checked at a stalling sink
   task automatic run_pix(input int np, input int nc);
      hcpc_pix_s p;
      fork
         begin
            @(posedge pclk);
            for (int i = 0; i < np; i++)
            begin
               p = rnd_pix();
               pix_in <= p;
               pix_in_valid <= 1'b1;
               do @(posedge pclk); while (pix_in_ready !== 1'b1);
               expq.push_back(exp_pix(p));
            end
            pix_in_valid <= 1'b0;
         end
         for (int k = 0; k < nc;)
         begin
            @(posedge pclk);
            if (pix_out_valid === 1'b1 && pix_out_ready === 1'b1)
            begin
               check("pixel", {24'h0, pix_out}, {24'h0, expq.pop_front()});
               k++;
            end
            pix_out_ready <= 1'($urandom);
         end
      join
   endtask
   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // ------------
   // Main sequence and watchdog
   // ------------
   initial
   begin
      #(40 * 60000);
      failures++;
      report_and_stop();
   end
   initial
   begin
      logic [31:0] mask [6] = '{32'h0000_003F, 32'h0003_FFFF, 32'h07FF_07FF, 32'h0000_00FF,
         32'h0000_00FF, 32'h0000_00FF};
      logic [31:0] d;
      int k;
      hcpc_pix_s p;
      void'($urandom(32'h5048_5895));
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      for (int a = 0; a < 32; a += 4) rdchk("reset", 8'(a), 32'h0000_0000, 1'b0);
      rdchk("unmapped", 8'h40, 32'h0000_0000, 1'b1);
      for (int i = 0; i < 6; i++)
      begin
         d = $urandom;
         wr(8'(4 * i), d);
         rdchk("readback", 8'(4 * i), d & mask[i], 1'b0);
      end
      wr(HCPC_OFS_STATUS, 32'hFFFF_FFFF);
      rdchk("status ro", HCPC_OFS_STATUS, 32'h0000_0000, 1'b0);
      load(1'b0, 1'b0);
      for (int i = 0; i < 16; i++)
      begin
         cfg(2'(i), i[2], i[3], 1'b1);
         run_pix(20, 20);
      end
      cfg(2'h3, 1'b1, 1'b1, 1'b0);
      run_pix(10, 10);
      load(1'b1, 1'b1);
      cfg(2'h2, 1'b0, 1'b0, 1'b1);
      run_pix(30, 30);
      pix_out_ready <= 1'b0;
      k = 0;
      @(posedge pclk);
      do
      begin
         p = rnd_pix();
         pix_in <= p;
         pix_in_valid <= 1'b1;
         @(posedge pclk);
         if (pix_in_ready === 1'b1)
         begin
            expq.push_back(exp_pix(p));
            k++;
         end
      end
      while (pix_in_ready === 1'b1 && k < 40);
      pix_in_valid <= 1'b0;
      check("fill depth", k, HCPC_FIFO_DEPTH + 1);
      run_pix(0, k);
      report_and_stop();
   end
endmodule
`default_nettype wire
